/* shared/aoc_pkg.sv */
// Package with register map, field layout, reset values and types of the analog output control block.
package aoc_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [4:0] AOC_IDX_WIDE1   = 5'h02;
  localparam logic [4:0] AOC_IDX_WIDE2   = 5'h03;
  localparam logic [4:0] AOC_IDX_NARROW3 = 5'h04;
  localparam logic [4:0] AOC_IDX_NARROW4 = 5'h05;
  localparam logic [4:0] AOC_IDX_SINK    = 5'h07;
  localparam logic [4:0] AOC_IDX_ENABLE  = 5'h0B;

  // Bus address layout: word aligned, five index bits above the byte lane bits.
  localparam int AOC_ADDR_W   = 7;
  localparam int AOC_ADDR_LSB = 2;

  // Field widths and positions.
  localparam int AOC_WIDE_W      = 10;
  localparam int AOC_NARROW_W    = 8;
  localparam int AOC_SINK_W      = 8;
  localparam int AOC_SINK_ONE_PIN_LSB   = 0;
  localparam int AOC_SINK_TWO_PIN_LSB   = 8;
  localparam int AOC_EN_W        = 6;
  localparam int AOC_EN_CH1_DIFF = 0;
  localparam int AOC_EN_CH2_DIFF = 1;
  localparam int AOC_EN_CH3_PIN  = 2;
  localparam int AOC_EN_CH4_PIN  = 3;
  localparam int AOC_EN_CH1_SE   = 4;
  localparam int AOC_EN_CH2_SE   = 5;

  // Sink strength per code step, in nanoamperes.
  localparam int AOC_SINK_STEP_NA = 62500;

  // Values after reset.
  localparam logic [9:0]  AOC_WIDE_RST   = 10'h000;
  localparam logic [7:0]  AOC_NARROW_RST = 8'h00;
  localparam logic [7:0]  AOC_SINK_RST   = 8'h00;
  localparam logic [5:0]  AOC_EN_RST     = 6'h00;
  localparam logic [31:0] AOC_WORD_ZERO  = 32'h0000_0000;

  // Bus encodings.
  localparam logic [2:0] AOC_HSIZE_WORD = 3'h2;
  localparam logic       AOC_HRESP_OKAY = 1'b0;

  // Software visible register contents.
  typedef struct packed {
    logic [9:0] wide1;
    logic [9:0] wide2;
    logic [7:0] narrow3;
    logic [7:0] narrow4;
    logic [7:0] sink_two;
    logic [7:0] sink_one;
    logic [5:0] enable;
  } aoc_regs_t;

  // Gated codes and enables presented to the converter stages.
  typedef struct packed {
    logic [9:0] pair1_code;
    logic       pair1_on;
    logic [9:0] ch1_pin_code;
    logic       ch1_pin_on;
    logic [9:0] pair2_code;
    logic       pair2_on;
    logic [9:0] ch2_pin_code;
    logic       ch2_pin_on;
    logic [7:0] ch3_code;
    logic       ch3_on;
    logic [7:0] ch4_code;
    logic       ch4_on;
    logic [7:0] sink_one_code;
    logic       sink_one_on;
    logic [7:0] sink_two_code;
    logic       sink_two_on;
  } aoc_outs_t;

  // Bus slave data phase kinds.
  typedef enum logic [1:0] {
    AOC_PH_IDLE  = 2'b00,
    AOC_PH_WRITE = 2'b01,
    AOC_PH_READ  = 2'b10
  } aoc_phase_t;

  // True when an index selects the given register.
  function automatic logic aoc_idx_hit(input logic [4:0] idx, input logic [4:0] reg_idx);
    return idx == reg_idx;
  endfunction : aoc_idx_hit

  // Read word of a register; reserved and unmapped bits read as zero.
  function automatic logic [31:0] aoc_read_word(input aoc_regs_t r, input logic [4:0] idx);
    logic [31:0] w;
    w = AOC_WORD_ZERO;
    if (aoc_idx_hit(idx, AOC_IDX_WIDE1)) w[9:0] = r.wide1;
    if (aoc_idx_hit(idx, AOC_IDX_WIDE2)) w[9:0] = r.wide2;
    if (aoc_idx_hit(idx, AOC_IDX_NARROW3)) w[7:0] = r.narrow3;
    if (aoc_idx_hit(idx, AOC_IDX_NARROW4)) w[7:0] = r.narrow4;
    if (aoc_idx_hit(idx, AOC_IDX_SINK)) w[15:0] = {r.sink_two, r.sink_one};
    if (aoc_idx_hit(idx, AOC_IDX_ENABLE)) w[5:0] = r.enable;
    return w;
  endfunction : aoc_read_word

  // Passes a code only while its enable is set.
  function automatic logic [9:0] aoc_gate(input logic [9:0] code, input logic en);
    return en ? code : 10'h000;
  endfunction : aoc_gate

endpackage : aoc_pkg

/* shared/aoc_reg_if.sv */
// Interface between the bus slave and the register file.
`timescale 1ns/10ps
interface aoc_reg_if;
  logic        wr_en;
  logic [4:0]  wr_idx;
  logic [31:0] wr_data;
  logic [4:0]  rd_idx;
  logic [31:0] rd_data;

  modport bus  (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : aoc_reg_if

/* src/aoc_ahb_slave.sv */
// AHB-Lite slave with zero wait states that turns transfers into register strobes.
`timescale 1ns/10ps
module aoc_ahb_slave
  import aoc_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [AOC_ADDR_W-1:0] haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  aoc_reg_if.bus                     rif
);

  typedef struct packed {
    aoc_phase_t  phase;
    logic [4:0]  idx;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } aoc_slv_t;

  aoc_slv_t s_q;
  aoc_slv_t s_d;

  //////////////////////////////////////////////////////////////////////////////
  // Address phase capture, write strobe in the data phase and read data capture.
  always_comb begin
    s_d           = s_q;
    s_d.hreadyout = 1'b1;
    s_d.hresp     = AOC_HRESP_OKAY;
    rif.wr_idx    = s_q.idx;
    rif.wr_data   = hwdata;
    rif.rd_idx    = haddr[AOC_ADDR_W-1:AOC_ADDR_LSB];
    case (s_q.phase)
      AOC_PH_WRITE: rif.wr_en = hready;
      AOC_PH_READ:  rif.wr_en = 1'b0;
      AOC_PH_IDLE:  rif.wr_en = 1'b0;
      default:      rif.wr_en = 1'b0;
    endcase
    if (hready) begin
      s_d.phase = AOC_PH_IDLE;
      // Only aligned whole-word transfers touch the registers; others complete as no-ops.
      if (hsel && htrans[1] && hsize == AOC_HSIZE_WORD && haddr[1:0] == 2'b00) begin
        s_d.idx   = haddr[AOC_ADDR_W-1:AOC_ADDR_LSB];
        s_d.phase = hwrite ? AOC_PH_WRITE : AOC_PH_READ;
        if (!hwrite) begin
          s_d.hrdata = rif.rd_data;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{phase: AOC_PH_IDLE, idx: 5'h00, hrdata: AOC_WORD_ZERO, hreadyout: 1'b1, hresp: AOC_HRESP_OKAY};
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.hreadyout;
  assign hrdata    = s_q.hrdata;
  assign hresp     = s_q.hresp;

endmodule : aoc_ahb_slave

/* src/aoc_out_stage.sv */
// Output stage that gates each channel code with its enable, derives the sink enables from the sink codes, and registers all for the converters.
`timescale 1ns/10ps
module aoc_out_stage
  import aoc_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire aoc_regs_t regs,
  output aoc_outs_t      outs
);

  aoc_outs_t o_q;
  aoc_outs_t o_d;

  //////////////////////////////////////////////////////////////////////////////
  // A disabled channel presents a zero code so the stored value has no effect.
  always_comb begin
    o_d               = o_q;
    o_d.pair1_on      = regs.enable[AOC_EN_CH1_DIFF];
    o_d.pair1_code    = aoc_gate(regs.wide1, regs.enable[AOC_EN_CH1_DIFF]);
    o_d.ch1_pin_on    = regs.enable[AOC_EN_CH1_SE];
    o_d.ch1_pin_code  = aoc_gate(regs.wide1, regs.enable[AOC_EN_CH1_SE]);
    o_d.pair2_on      = regs.enable[AOC_EN_CH2_DIFF];
    o_d.pair2_code    = aoc_gate(regs.wide2, regs.enable[AOC_EN_CH2_DIFF]);
    o_d.ch2_pin_on    = regs.enable[AOC_EN_CH2_SE];
    o_d.ch2_pin_code  = aoc_gate(regs.wide2, regs.enable[AOC_EN_CH2_SE]);
    o_d.ch3_on        = regs.enable[AOC_EN_CH3_PIN];
    o_d.ch3_code      = regs.enable[AOC_EN_CH3_PIN] ? regs.narrow3 : AOC_NARROW_RST;
    o_d.ch4_on        = regs.enable[AOC_EN_CH4_PIN];
    o_d.ch4_code      = regs.enable[AOC_EN_CH4_PIN] ? regs.narrow4 : AOC_NARROW_RST;
    // A nonzero sink code both enables the sink and sets its strength.
    o_d.sink_one_on   = |regs.sink_one;
    o_d.sink_one_code = regs.sink_one;
    o_d.sink_two_on   = |regs.sink_two;
    o_d.sink_two_code = regs.sink_two;
  end

  // Output register; everything reads zero and off after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      o_q <= '0;
    end else begin
      o_q <= o_d;
    end
  end

  assign outs = o_q;

endmodule : aoc_out_stage

/* src/aoc_top.sv */
// Top of the analog output control block: register file, bus slave, output stage and checks.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module aoc_top
  import aoc_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [AOC_ADDR_W-1:0] haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  output logic [9:0]                 first_differential_pair_code,
  output logic                       first_differential_pair_on,
  output logic [9:0]                 wide_ch1_pin_code,
  output logic                       wide_ch1_pin_on,
  output logic [9:0]                 second_differential_pair_code,
  output logic                       second_differential_pair_on,
  output logic [9:0]                 wide_ch2_pin_code,
  output logic                       wide_ch2_pin_on,
  output logic [7:0]                 narrow_ch3_pin_code,
  output logic                       narrow_ch3_pin_on,
  output logic [7:0]                 narrow_ch4_pin_code,
  output logic                       narrow_ch4_pin_on,
  output logic [7:0]                 sink_one_pin_code,
  output logic                       sink_one_pin_on,
  output logic [7:0]                 sink_two_pin_code,
  output logic                       sink_two_pin_on
);

  aoc_reg_if rif ();
  aoc_regs_t regs_q;
  aoc_regs_t regs_d;
  aoc_outs_t outs;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave.
  aoc_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .rif       (rif.bus)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register file; only the documented bits of each word are stored.
  always_comb begin
    regs_d = regs_q;
    if (rif.wr_en) begin
      if (aoc_idx_hit(rif.wr_idx, AOC_IDX_WIDE1)) begin
        regs_d.wide1 = rif.wr_data[AOC_WIDE_W-1:0];
      end
      if (aoc_idx_hit(rif.wr_idx, AOC_IDX_WIDE2)) begin
        regs_d.wide2 = rif.wr_data[AOC_WIDE_W-1:0];
      end
      if (aoc_idx_hit(rif.wr_idx, AOC_IDX_NARROW3)) begin
        regs_d.narrow3 = rif.wr_data[AOC_NARROW_W-1:0];
      end
      if (aoc_idx_hit(rif.wr_idx, AOC_IDX_NARROW4)) begin
        regs_d.narrow4 = rif.wr_data[AOC_NARROW_W-1:0];
      end
      if (aoc_idx_hit(rif.wr_idx, AOC_IDX_SINK)) begin
        regs_d.sink_two = rif.wr_data[AOC_SINK_TWO_PIN_LSB +: AOC_SINK_W];
        regs_d.sink_one = rif.wr_data[AOC_SINK_ONE_PIN_LSB +: AOC_SINK_W];
      end
      if (aoc_idx_hit(rif.wr_idx, AOC_IDX_ENABLE)) begin
        regs_d.enable = rif.wr_data[AOC_EN_W-1:0];
      end
    end
  end

  // Register state; reset leaves every output at zero and both sinks off.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      regs_q <= '{wide1: AOC_WIDE_RST, wide2: AOC_WIDE_RST, narrow3: AOC_NARROW_RST,
                  narrow4: AOC_NARROW_RST, sink_two: AOC_SINK_RST, sink_one: AOC_SINK_RST,
                  enable: AOC_EN_RST};
    end else begin
      regs_q <= regs_d;
    end
  end

  // Read data comes from the next-state copy, so a read right after a write sees the new value.
  assign rif.rd_data = aoc_read_word(regs_d, rif.rd_idx);

  //////////////////////////////////////////////////////////////////////////////
  // Gating of codes onto the dedicated converter outputs; no port sharing applies.
  aoc_out_stage u_out (
    .hclk    (hclk),
    .hresetn (hresetn),
    .regs    (regs_q),
    .outs    (outs)
  );

  // Ports are driven straight from the output stage registers.
  assign first_differential_pair_code  = outs.pair1_code;
  assign first_differential_pair_on    = outs.pair1_on;
  assign wide_ch1_pin_code             = outs.ch1_pin_code;
  assign wide_ch1_pin_on               = outs.ch1_pin_on;
  assign second_differential_pair_code = outs.pair2_code;
  assign second_differential_pair_on   = outs.pair2_on;
  assign wide_ch2_pin_code             = outs.ch2_pin_code;
  assign wide_ch2_pin_on               = outs.ch2_pin_on;
  assign narrow_ch3_pin_code           = outs.ch3_code;
  assign narrow_ch3_pin_on             = outs.ch3_on;
  assign narrow_ch4_pin_code           = outs.ch4_code;
  assign narrow_ch4_pin_on             = outs.ch4_on;
  assign sink_one_pin_code             = outs.sink_one_code;
  assign sink_one_pin_on               = outs.sink_one_on;
  assign sink_two_pin_code             = outs.sink_two_code;
  assign sink_two_pin_on               = outs.sink_two_on;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on stored codes, routing and reset values.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // A bus write to a register index.
  sequence s_wr_wide1;
    rif.wr_en && rif.wr_idx == AOC_IDX_WIDE1;
  endsequence
  sequence s_wr_wide2;
    rif.wr_en && rif.wr_idx == AOC_IDX_WIDE2;
  endsequence
  sequence s_wr_enable;
    rif.wr_en && rif.wr_idx == AOC_IDX_ENABLE;
  endsequence
  sequence s_wr_narrow3;
    rif.wr_en && rif.wr_idx == AOC_IDX_NARROW3;
  endsequence
  sequence s_wr_narrow4;
    rif.wr_en && rif.wr_idx == AOC_IDX_NARROW4;
  endsequence
  sequence s_wr_sink;
    rif.wr_en && rif.wr_idx == AOC_IDX_SINK;
  endsequence
  // A whole-word read of either wide channel taken on the bus.
  sequence s_rd_wide;
    hready && hsel && htrans[1] && !hwrite && hsize == AOC_HSIZE_WORD && haddr[1:0] == 2'b00
      && (rif.rd_idx == AOC_IDX_WIDE1 || rif.rd_idx == AOC_IDX_WIDE2);
  endsequence

  // Wide channel one stores the low ten bits and reads zero above them.
  property p_wide1_store;
    s_wr_wide1 |=> regs_q.wide1 == $past(rif.wr_data[9:0])
      && (aoc_read_word(regs_q, AOC_IDX_WIDE1) >> AOC_WIDE_W) == AOC_WORD_ZERO;
  endproperty
  a_wide1_store: assert property (p_wide1_store) else $error("wide channel one store wrong");

  // Writing enable bit 0 puts channel one code on the first pair two edges later.
  property p_pair1_route;
    (s_wr_enable ##0 rif.wr_data[0]) ##1 $stable(regs_q.wide1)
      |=> first_differential_pair_on && first_differential_pair_code == $past(regs_q.wide1);
  endproperty
  a_pair1_route: assert property (p_pair1_route) else $error("first pair not driven");

  // Enable bit 4 puts channel one code on its pin one edge later.
  property p_ch1_pin_route;
    regs_q.enable[AOC_EN_CH1_SE] |=> wide_ch1_pin_on && wide_ch1_pin_code == $past(regs_q.wide1);
  endproperty
  a_ch1_pin_route: assert property (p_ch1_pin_route) else $error("channel one pin not driven");

  // With both channel one enables clear, no channel one output shows the code.
  property p_ch1_silent;
    !regs_q.enable[AOC_EN_CH1_DIFF] && !regs_q.enable[AOC_EN_CH1_SE]
      |=> !first_differential_pair_on && !wide_ch1_pin_on
          && first_differential_pair_code == 10'h000 && wide_ch1_pin_code == 10'h000;
  endproperty
  a_ch1_silent: assert property (p_ch1_silent) else $error("channel one leaks while disabled");

  // Wide channel two stores the low ten bits and reads zero above them.
  property p_wide2_store;
    s_wr_wide2 |=> regs_q.wide2 == $past(rif.wr_data[9:0])
      && (aoc_read_word(regs_q, AOC_IDX_WIDE2) >> AOC_WIDE_W) == AOC_WORD_ZERO;
  endproperty
  a_wide2_store: assert property (p_wide2_store) else $error("wide channel two store wrong");

  // Enable bit 1 puts channel two code on the second pair one edge later.
  property p_pair2_route;
    regs_q.enable[AOC_EN_CH2_DIFF]
      |=> second_differential_pair_on && second_differential_pair_code == $past(regs_q.wide2);
  endproperty
  a_pair2_route: assert property (p_pair2_route) else $error("second pair not driven");

  // With enable bit 1 clear the second pair is off and shows a zero code.
  property p_pair2_off;
    !regs_q.enable[AOC_EN_CH2_DIFF] |=> !second_differential_pair_on && second_differential_pair_code == 10'h000;
  endproperty
  a_pair2_off: assert property (p_pair2_off) else $error("second pair on while disabled");

  // Enable bit 5 drives channel two pin; clear means zero code.
  property p_ch2_pin_route;
    wide_ch2_pin_code == ($past(regs_q.enable[AOC_EN_CH2_SE]) ? $past(regs_q.wide2) : 10'h000)
      && wide_ch2_pin_on == $past(regs_q.enable[AOC_EN_CH2_SE]);
  endproperty
  a_ch2_pin_route: assert property (p_ch2_pin_route) else $error("channel two pin wrong");

  // Channel three pin shows its code only while enable bit 2 is set.
  property p_ch3_gate;
    narrow_ch3_pin_code == ($past(regs_q.enable[AOC_EN_CH3_PIN]) ? $past(regs_q.narrow3) : 8'h00)
      && narrow_ch3_pin_on == $past(regs_q.enable[AOC_EN_CH3_PIN]);
  endproperty
  a_ch3_gate: assert property (p_ch3_gate) else $error("channel three gating wrong");

  // Channel four pin shows its code only while enable bit 3 is set.
  property p_ch4_gate;
    narrow_ch4_pin_code == ($past(regs_q.enable[AOC_EN_CH4_PIN]) ? $past(regs_q.narrow4) : 8'h00)
      && narrow_ch4_pin_on == $past(regs_q.enable[AOC_EN_CH4_PIN]);
  endproperty
  a_ch4_gate: assert property (p_ch4_gate) else $error("channel four gating wrong");

  // A zero code in the upper sink field keeps sink two off.
  property p_sink_two_pin_off;
    regs_q.sink_two == 8'h00 |=> !sink_two_pin_on;
  endproperty
  a_sink_two_pin_off: assert property (p_sink_two_pin_off) else $error("sink two on with zero code");

  // A nonzero upper field turns sink two on with that strength code.
  property p_sink_two_pin_on;
    regs_q.sink_two != 8'h00 |=> sink_two_pin_on && sink_two_pin_code == $past(regs_q.sink_two);
  endproperty
  a_sink_two_pin_on: assert property (p_sink_two_pin_on) else $error("sink two not enabled");

  // A zero code in the lower sink field keeps sink one off.
  property p_sink_one_pin_off;
    regs_q.sink_one == 8'h00 |=> !sink_one_pin_on;
  endproperty
  a_sink_one_pin_off: assert property (p_sink_one_pin_off) else $error("sink one on with zero code");

  // A nonzero lower field turns sink one on with that strength code.
  property p_sink_one_pin_on;
    regs_q.sink_one != 8'h00 |=> sink_one_pin_on && sink_one_pin_code == $past(regs_q.sink_one);
  endproperty
  a_sink_one_pin_on: assert property (p_sink_one_pin_on) else $error("sink one not enabled");

  // Narrow channel three stores all eight written bits.
  property p_narrow3_store;
    s_wr_narrow3 |=> regs_q.narrow3 == $past(rif.wr_data[7:0]);
  endproperty
  a_narrow3_store: assert property (p_narrow3_store) else $error("channel three store wrong");

  // Narrow channel four stores all eight written bits.
  property p_narrow4_store;
    s_wr_narrow4 |=> regs_q.narrow4 == $past(rif.wr_data[7:0]);
  endproperty
  a_narrow4_store: assert property (p_narrow4_store) else $error("channel four store wrong");

  // The sink control word splits into its two sink fields.
  property p_sink_store;
    s_wr_sink |=> regs_q.sink_two == $past(rif.wr_data[15:8])
      && regs_q.sink_one == $past(rif.wr_data[7:0]);
  endproperty
  a_sink_store: assert property (p_sink_store) else $error("sink control store wrong");

  // The enable word keeps its six routing bits.
  property p_enable_store;
    s_wr_enable |=> regs_q.enable == $past(rif.wr_data[5:0]);
  endproperty
  a_enable_store: assert property (p_enable_store) else $error("enable store wrong");

  // Reserved bits of a wide channel read back as zero on the bus.
  property p_wide_rd_upper;
    s_rd_wide |=> hrdata[31:AOC_WIDE_W] == 22'h00_0000;
  endproperty
  a_wide_rd_upper: assert property (p_wide_rd_upper) else $error("wide reserved bits not zero");

  // The slave never inserts a wait state and always answers OKAY.
  property p_bus_okay;
    hreadyout && hresp == AOC_HRESP_OKAY;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus slave stalled or errored");

  // Right after reset release every stored field and every output is zero.
  property p_reset_clear;
    $rose(hresetn) |-> regs_q == '0 && outs == '0;
  endproperty
  a_reset_clear: assert property (@(posedge hclk) p_reset_clear) else $error("state not clear after reset");

endmodule : aoc_top

/* verif/aoc_top_bench.sv */
// Self-checking testbench of the analog output control block, driven over AHB-Lite.
`timescale 1ns/10ps
module aoc_top_bench import aoc_pkg::*;;
  logic                  hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [AOC_ADDR_W-1:0] haddr;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           hwdata, hrdata, rd_q, seed_q;
  logic [9:0]            p1_code, c1_code, p2_code, c2_code, m_w1, m_w2;
  logic [7:0]            c3_code, c4_code, s1_code, s2_code, m_n3, m_n4, m_s1, m_s2;
  logic                  p1_on, c1_on, p2_on, c2_on, c3_on, c4_on, s1_on, s2_on;
  logic [5:0]            m_en;
  int                    err_count, tests_run;
  logic [4:0]            idx_tab [8];

  assign hready = hreadyout;

  ////////////////////////////////////////////////////////////////////////////////
  aoc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .first_differential_pair_code(p1_code), .first_differential_pair_on(p1_on),
    .wide_ch1_pin_code(c1_code), .wide_ch1_pin_on(c1_on),
    .second_differential_pair_code(p2_code), .second_differential_pair_on(p2_on),
    .wide_ch2_pin_code(c2_code), .wide_ch2_pin_on(c2_on),
    .narrow_ch3_pin_code(c3_code), .narrow_ch3_pin_on(c3_on),
    .narrow_ch4_pin_code(c4_code), .narrow_ch4_pin_on(c4_on),
    .sink_one_pin_code(s1_code), .sink_one_pin_on(s1_on), .sink_two_pin_code(s2_code), .sink_two_pin_on(s2_on));

  // The clock toggles every half period of 10 ns.
  always #10 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Xorshift generator; the fixed start value makes every run the same.
  function automatic logic [31:0] xs();
    seed_q = seed_q ^ (seed_q << 13);
    seed_q = seed_q ^ (seed_q >> 17);
    seed_q = seed_q ^ (seed_q << 5);
    return seed_q;
  endfunction : xs

  // Expected read word from the bench's own copy of the registers.
  function automatic logic [31:0] exp_rd(input logic [4:0] idx);
    if (idx == AOC_IDX_WIDE1) return {22'h00_0000, m_w1};
    if (idx == AOC_IDX_WIDE2) return {22'h00_0000, m_w2};
    if (idx == AOC_IDX_NARROW3) return {24'h00_0000, m_n3};
    if (idx == AOC_IDX_NARROW4) return {24'h00_0000, m_n4};
    if (idx == AOC_IDX_SINK) return {16'h0000, m_s2, m_s1};
    if (idx == AOC_IDX_ENABLE) return {26'h000_0000, m_en};
    return 32'h0000_0000;
  endfunction : exp_rd

  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One single word transfer; the address phase is held until hready is seen high.
  task automatic op(input logic [4:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= AOC_HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0000_0000, hresp}, {31'h0000_0000, AOC_HRESP_OKAY});
  endtask : op

  // Checks every converter output against the gating expected from the copy.
  task automatic check_outs();
    check("pair1", 32'({p1_on, p1_code}), m_en[AOC_EN_CH1_DIFF] ? 32'({1'b1, m_w1}) : 32'h0000_0000);
    check("pin1", 32'({c1_on, c1_code}), m_en[AOC_EN_CH1_SE] ? 32'({1'b1, m_w1}) : 32'h0000_0000);
    check("pair2", 32'({p2_on, p2_code}), m_en[AOC_EN_CH2_DIFF] ? 32'({1'b1, m_w2}) : 32'h0000_0000);
    check("pin2", 32'({c2_on, c2_code}), m_en[AOC_EN_CH2_SE] ? 32'({1'b1, m_w2}) : 32'h0000_0000);
    check("pin3", 32'({c3_on, c3_code}), m_en[AOC_EN_CH3_PIN] ? 32'({1'b1, m_n3}) : 32'h0000_0000);
    check("pin4", 32'({c4_on, c4_code}), m_en[AOC_EN_CH4_PIN] ? 32'({1'b1, m_n4}) : 32'h0000_0000);
    check("sink_one_pin", 32'({s1_on, s1_code}), 32'({m_s1 != 8'h00, m_s1}));
    check("sink_two_pin", 32'({s2_on, s2_code}), 32'({m_s2 != 8'h00, m_s2}));
  endtask : check_outs

  // Writes a word, updates the copy, reads the word back and checks all outputs.
  task automatic wr_chk(input logic [4:0] idx, input logic [31:0] d);
    op(idx, 1'b1, d, rd_q);
    if (idx == AOC_IDX_WIDE1) m_w1 = d[9:0];
    if (idx == AOC_IDX_WIDE2) m_w2 = d[9:0];
    if (idx == AOC_IDX_NARROW3) m_n3 = d[7:0];
    if (idx == AOC_IDX_NARROW4) m_n4 = d[7:0];
    if (idx == AOC_IDX_SINK) {m_s2, m_s1} = d[15:0];
    if (idx == AOC_IDX_ENABLE) m_en = d[5:0];
    op(idx, 1'b0, xs(), rd_q);
    check("readback", rd_q, exp_rd(idx));
    #1;
    check_outs();
    @(posedge hclk);
  endtask : wr_chk

  // Reads every register and checks the all-zero state after a reset.
  task automatic check_reset();
    {m_w1, m_w2, m_n3, m_n4, m_s1, m_s2, m_en} = '0;
    for (int i = 0; i < 8; i++) begin
      op(idx_tab[i], 1'b0, 32'h0000_0000, rd_q);
      check("reset read", rd_q, 32'h0000_0000);
    end
    #1;
    check_outs();
    @(posedge hclk);
  endtask : check_reset

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, corner cases, random traffic, reset in mid-run.
  initial begin
    idx_tab = '{AOC_IDX_WIDE1, AOC_IDX_WIDE2, AOC_IDX_NARROW3, AOC_IDX_NARROW4, AOC_IDX_SINK, AOC_IDX_ENABLE,
                5'h00, 5'h1F};
    {hclk, hresetn, hsel, hwrite, haddr, htrans, hwdata, err_count, tests_run} = '0;
    hsize = AOC_HSIZE_WORD;
    seed_q = 32'h0000_0028;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    check_reset();
    $display("test reset values done");
    wr_chk(AOC_IDX_WIDE1, 32'hFFFF_FFFF);
    wr_chk(AOC_IDX_WIDE2, 32'hFFFF_FC00);
    wr_chk(AOC_IDX_WIDE2, 32'h0000_0155);
    wr_chk(AOC_IDX_NARROW3, 32'h0000_00FF);
    wr_chk(AOC_IDX_NARROW4, 32'h0000_0080);
    for (int i = 0; i < 6; i++) wr_chk(AOC_IDX_ENABLE, 32'(6'h01 << i));
    wr_chk(AOC_IDX_ENABLE, 32'h0000_00C0);
    wr_chk(AOC_IDX_ENABLE, 32'h0000_003F);
    wr_chk(AOC_IDX_SINK, 32'h0000_FF00);
    wr_chk(AOC_IDX_SINK, 32'h0000_0001);
    wr_chk(5'h1F, 32'hFFFF_FFFF);
    $display("test corner cases done");
    for (int i = 0; i < 60; i++) wr_chk(idx_tab[xs() % 8], xs());
    $display("test random traffic done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    check_reset();
    $display("test reset in mid-run done");
    conclude();
  end

  // Cuts a hang short well beyond the roughly 430 cycles the tests take.
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    conclude();
  end
endmodule : aoc_top_bench
